// ---- spx_pkg.sv ----
// constants, types and helpers shared by the serial port files
package spx_pkg;
    // register byte addresses
    localparam logic [31:0] ADR_STATUS = 32'hFFFF0A00;
    localparam logic [31:0] ADR_RX     = 32'hFFFF0A04;
    localparam logic [31:0] ADR_TX     = 32'hFFFF0A08;
    localparam logic [31:0] ADR_DIV    = 32'hFFFF0A0C;
    localparam logic [31:0] ADR_CTRL   = 32'hFFFF0A10;
    // reset values
    localparam logic [7:0]  DIV_RESET    = 8'h1B;
    localparam logic [3:0]  CTRL_RESET   = 4'h0;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // control field positions
    localparam int CTRL_EN   = 0;
    localparam int CTRL_MST  = 1;
    localparam int CTRL_CPOL = 2;
    localparam int CTRL_CPHA = 3;
    // status field positions
    localparam int ST_RXCNT = 8;
    localparam int ST_OVF   = 7;
    localparam int ST_UDF   = 4;
    localparam int ST_TXCNT = 1;
    // sizes
    localparam int BYTE_W  = 8;
    localparam int DEPTH   = 4;
    localparam int CNT_W   = 3;
    localparam int PTR_W   = 2;
    localparam logic [3:0] LAST_EDGE = 4'hF;
    // timing: slave edges must be slower than this
    localparam int CLK_MHZ      = 200;
    localparam int SLV_MAX_MBPS = 10;
    localparam int SLV_HALF_CYC = CLK_MHZ / (2 * SLV_MAX_MBPS);

    // master state machine
    typedef enum logic [1:0] {M_IDLE, M_RUN, M_END} spx_mst_e;

    // assemble the status word from its fields
    function automatic logic [15:0] status_word(input logic [2:0] rxc,
                                                input logic       ovf,
                                                input logic       udf,
                                                input logic [2:0] txc);
        logic [15:0] w;
        w = STATUS_RESET;
        w[ST_RXCNT +: CNT_W] = rxc;
        w[ST_OVF] = ovf;
        w[ST_UDF] = udf;
        w[ST_TXCNT +: CNT_W] = txc;
        return w;
    endfunction
endpackage

// ---- spx_fifo_if.sv ----
// byte fifo connection between the port and its fifos
`timescale 1ns/1ps
interface spx_fifo_if;
    logic                          push;   // write strobe
    logic [spx_pkg::BYTE_W-1:0]    wdata;  // write byte
    logic                          pop;    // read strobe
    logic [spx_pkg::BYTE_W-1:0]    rdata;  // head byte
    logic [spx_pkg::CNT_W-1:0]     count;  // bytes held
    logic                          full;   // no room
    logic                          empty;  // nothing held
    modport fifo (input push, wdata, pop, output rdata, count, full, empty);
    modport user (output push, wdata, pop, input rdata, count, full, empty);
endinterface

// ---- spx_sync.sv ----
// two-stage synchronisers for the serial pins
`timescale 1ns/1ps
module spx_sync #(
    parameter int              W    = 1,
    parameter logic [W-1:0]    INIT = '0
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [W-1:0]  d_i,
    output logic      [W-1:0]  q_o
);
    logic [W-1:0] s1_q;  // first stage, read only by second
    logic [W-1:0] s2_q;  // second stage
    genvar g;
    // one synchroniser per bit
    for (g = 0; g < W; g++)
    begin : g_bit
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                s1_q[g] <= INIT[g];
                s2_q[g] <= INIT[g];
            end
            else
            begin
                s1_q[g] <= d_i[g];
                s2_q[g] <= s1_q[g];
            end
        end
    end
    assign q_o = s2_q;
endmodule

// ---- spx_fifo.sv ----
// four-byte fifo with counts for status
`timescale 1ns/1ps
module spx_fifo (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    spx_fifo_if.fifo   f
);
    logic [spx_pkg::BYTE_W-1:0] mem [spx_pkg::DEPTH];  // storage
    logic [spx_pkg::PTR_W-1:0]  wp_q;                  // write pointer
    logic [spx_pkg::PTR_W-1:0]  rp_q;                  // read pointer
    logic [spx_pkg::CNT_W-1:0]  cnt_q;                 // fill level
    wire do_push = f.push & ~f.full;   // full drops the byte
    wire do_pop  = f.pop & ~f.empty;   // empty ignores pop

    assign f.full  = (cnt_q == spx_pkg::CNT_W'(spx_pkg::DEPTH));
    assign f.empty = (cnt_q == '0);
    assign f.count = cnt_q;
    assign f.rdata = mem[rp_q];

    // storage has no reset
    always_ff @(posedge clk_i)
    begin
        if (do_push)
            mem[wp_q] <= f.wdata;
    end

    // pointers and level
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wp_q  <= wp_q + PTR_ONE(do_push);
            rp_q  <= rp_q + PTR_ONE(do_pop);
            cnt_q <= cnt_q + {2'h0, do_push} - {2'h0, do_pop};
        end
    end

    // pointer step of zero or one
    function automatic logic [spx_pkg::PTR_W-1:0] PTR_ONE(input logic b);
        return {1'b0, b};
    endfunction
endmodule

// ---- spx_port.sv ----
// serial peripheral port, master or slave, with wishbone registers
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module spx_port (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        stb_i,
    input  wire logic        cyc_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        master_in_slave_out_pin_i,
    output logic             master_in_slave_out_pin_o,
    output logic             master_in_slave_out_pin_oe_o,
    input  wire logic        master_out_slave_in_pin_i,
    output logic             master_out_slave_in_pin_o,
    output logic             master_out_slave_in_pin_oe_o,
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe_o,
    input  wire logic        chip_select_pin_n_i,
    output logic             chip_select_pin_n_o,
    output logic             chip_select_pin_n_oe_o
);
    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [3:0]          ctrl_q;    // serial_port_control
    logic [7:0]          div_q;     // serial_clock_divider
    logic                ovf_q;     // receive_overflow_flag
    logic                udf_q;     // transmit_underflow_flag
    logic                ack_q;     // bus answer
    logic [31:0]         dat_q;     // bus read data
    spx_pkg::spx_mst_e   st_q;      // master sequencer
    logic [7:0]          dcnt_q;    // half-period divider
    logic                sclk_q;    // generated serial clock
    logic                cs_q;      // generated chip select, low active
    logic [3:0]          ecnt_q;    // clock edge index in byte
    logic [7:0]          tx_sr_q;   // outgoing shift register
    logic [7:0]          rx_sr_q;   // incoming shift register
    logic                sclk_p_q;  // previous synced clock
    logic                cs_p_q;    // previous synced select
    logic                keep_q;    // hold last bit until next leading edge
    logic                keep_bit_q; // bit held on the data line meanwhile

    spx_fifo_if txf ();
    spx_fifo_if rxf ();

    ////////////////////////////////////////////////////////////////////////
    // configuration decode
    wire en   = ctrl_q[spx_pkg::CTRL_EN];
    wire mst  = en & ctrl_q[spx_pkg::CTRL_MST];
    wire slv  = en & ~ctrl_q[spx_pkg::CTRL_MST];
    wire cpol = ctrl_q[spx_pkg::CTRL_CPOL];
    wire cpha = ctrl_q[spx_pkg::CTRL_CPHA];

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, all four inputs come from outside
    logic [3:0] pin_s;
    // slave edges of 10 Mb leave several cycles per half period
    spx_sync #(.W(4), .INIT(4'h8)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({chip_select_pin_n_i, serial_clock_pin_i,
                 master_out_slave_in_pin_i, master_in_slave_out_pin_i}),
        .q_o   (pin_s)
    );
    wire cs_s   = pin_s[3];
    wire sclk_s = pin_s[2];
    wire mosi_s = pin_s[1];
    wire miso_s = pin_s[0];

    ////////////////////////////////////////////////////////////////////////
    // fifos
    spx_fifo u_txf (.clk_i(clk_i), .rst_i(rst_i), .f(txf.fifo));
    spx_fifo u_rxf (.clk_i(clk_i), .rst_i(rst_i), .f(rxf.fifo));

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire req    = cyc_i & stb_i;
    wire acc    = req & ~ack_q;      // sampling cycle
    wire fin    = req & ack_q;       // effect edge
    wire hit_st = (adr_i == spx_pkg::ADR_STATUS);
    wire hit_rx = (adr_i == spx_pkg::ADR_RX);
    wire hit_tx = (adr_i == spx_pkg::ADR_TX);
    wire hit_dv = (adr_i == spx_pkg::ADR_DIV);
    wire hit_ct = (adr_i == spx_pkg::ADR_CTRL);
    wire wr_ok  = fin & we_i & sel_i[0];
    wire wr_tx  = wr_ok & hit_tx;
    wire wr_dv  = wr_ok & hit_dv;
    wire wr_ct  = wr_ok & hit_ct;
    wire rd_rx  = fin & ~we_i & hit_rx;
    wire rd_st  = fin & ~we_i & hit_st;

    // status word, no write path reaches it
    wire [15:0] status = spx_pkg::status_word(rxf.count, ovf_q, udf_q,
                                              txf.count);
    // read mux, unmapped reads give zero
    wire [31:0] rd_mux = hit_st ? {16'h0000, status} :
                         hit_rx ? {24'h000000, rxf.rdata} :
                         hit_dv ? {24'h000000, div_q} :
                         hit_ct ? {28'h0000000, ctrl_q} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // shift engine events shared by both roles
    wire tick      = (dcnt_q == div_q);
    wire slv_act   = slv & ~cs_s;
    wire slv_start = slv & cs_p_q & ~cs_s;
    wire mst_start = mst & (st_q == spx_pkg::M_IDLE) & ~txf.empty;
    wire run       = mst ? (st_q == spx_pkg::M_RUN) : slv_act;
    wire edge_ev   = mst ? (run & tick) : (slv_act & (sclk_s ^ sclk_p_q));
    wire din       = mst ? miso_s : mosi_s;
    // even edges lead, odd edges trail; phase picks the sampling one
    wire sample_ev = edge_ev & (ecnt_q[0] == cpha);
    wire launch_ev = edge_ev & (ecnt_q[0] != cpha) & (ecnt_q != '0);
    wire done      = edge_ev & (ecnt_q == spx_pkg::LAST_EDGE);
    wire more      = done & (slv | ~txf.empty);
    wire load_ev   = mst_start | slv_start | more;
    wire udf_set   = load_ev & txf.empty;
    wire ovf_set   = done & rxf.full;
    // last bit may arrive on the closing edge
    wire [7:0] rx_byte = sample_ev ? {rx_sr_q[6:0], din} : rx_sr_q;

    assign txf.push  = wr_tx;
    assign txf.wdata = dat_i[7:0];
    assign txf.pop   = load_ev;
    assign rxf.push  = done;
    assign rxf.wdata = rx_byte;
    assign rxf.pop   = rd_rx;

    ////////////////////////////////////////////////////////////////////////
    // wishbone answer and read data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end
        else
        begin
            ack_q <= acc;
            if (acc)
                dat_q <= rd_mux;
        end
    end

    // software registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= spx_pkg::CTRL_RESET;
            div_q  <= spx_pkg::DIV_RESET;
        end
        else
        begin
            if (wr_ct)
                ctrl_q <= dat_i[3:0];
            if (wr_dv)
                div_q <= dat_i[7:0];
        end
    end

    // sticky flags: set wins, read clears only what was reported
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ovf_q <= 1'b0;
            udf_q <= 1'b0;
        end
        else
        begin
            ovf_q <= ovf_set | (ovf_q & ~(rd_st & dat_q[spx_pkg::ST_OVF]));
            udf_q <= udf_set | (udf_q & ~(rd_st & dat_q[spx_pkg::ST_UDF]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master sequencer: select, divider and clock generation
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q   <= spx_pkg::M_IDLE;
            dcnt_q <= '0;
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
        end
        else if (!mst)
        begin
            // role change or disable aborts the transfer
            st_q   <= spx_pkg::M_IDLE;
            dcnt_q <= '0;
            sclk_q <= cpol;
            cs_q   <= 1'b1;
        end
        else
        begin
            dcnt_q <= (tick || st_q == spx_pkg::M_IDLE) ? '0 : dcnt_q + 8'h01;
            case (st_q)
                spx_pkg::M_IDLE:
                begin
                    sclk_q <= cpol;
                    if (mst_start)
                    begin
                        cs_q <= 1'b0;
                        st_q <= spx_pkg::M_RUN;
                    end
                end
                spx_pkg::M_RUN:
                begin
                    if (tick)
                        sclk_q <= ~sclk_q;
                    if (done && txf.empty)
                        st_q <= spx_pkg::M_END;
                end
                spx_pkg::M_END:
                begin
                    // hold select a half period past the last edge
                    if (tick)
                    begin
                        cs_q <= 1'b1;
                        st_q <= spx_pkg::M_IDLE;
                    end
                end
                default:
                begin
                    st_q <= spx_pkg::M_IDLE;
                    cs_q <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge index and shift registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ecnt_q   <= '0;
            tx_sr_q  <= '0;
            rx_sr_q  <= '0;
            sclk_p_q <= 1'b0;
            cs_p_q   <= 1'b1;
        end
        else
        begin
            sclk_p_q <= sclk_s;
            cs_p_q   <= cs_s;
            // sixteen edges make one byte
            if (!run || load_ev && !more)
                ecnt_q <= '0;
            else if (edge_ev)
                ecnt_q <= ecnt_q + 4'h1;
            // empty fifo sends zeros
            if (load_ev)
                tx_sr_q <= txf.empty ? 8'h00 : txf.rdata;
            else if (launch_ev)
                tx_sr_q <= {tx_sr_q[6:0], 1'b0};
            if (sample_ev)
                rx_sr_q <= {rx_sr_q[6:0], din};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase one reloads on a sample edge; the new msb must wait for edge 0
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            keep_q     <= 1'b0;
            keep_bit_q <= 1'b0;
        end
        else if (more && cpha)
        begin
            keep_q     <= 1'b1;
            keep_bit_q <= tx_sr_q[7];
        end
        else if (edge_ev || !run)
            keep_q <= 1'b0;
    end
    wire tx_bit = keep_q ? keep_bit_q : tx_sr_q[7];

    ////////////////////////////////////////////////////////////////////////
    // pin drivers, direction follows the role
    assign master_in_slave_out_pin_o    = tx_bit;
    assign master_in_slave_out_pin_oe_o = slv;
    assign master_out_slave_in_pin_o    = tx_bit;
    assign master_out_slave_in_pin_oe_o = mst;
    assign serial_clock_pin_o           = sclk_q;
    assign serial_clock_pin_oe_o        = mst;
    assign chip_select_pin_n_o          = cs_q;
    assign chip_select_pin_n_oe_o       = mst;
    assign dat_o                        = dat_q;
    assign ack_o                        = ack_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [7:0] hold_q;   // cycles since generated clock moved
    logic [4:0] tog_q;    // clock toggles in current master burst
    always_ff @(posedge clk_i)
    begin
        if (rst_i || sclk_q != $past(sclk_q) || $past(mst_start))
            hold_q <= '0;
        else
            hold_q <= hold_q + 8'h01;
        if (rst_i || mst_start)
            tog_q <= '0;
        else if (sclk_q != $past(sclk_q) && $past(st_q) == spx_pkg::M_RUN)
            tog_q <= tog_q + 5'h01;
    end

    sequence s_start;
        mst_start;
    endsequence
    sequence s_sel_low;
        !cs_q && st_q == spx_pkg::M_RUN;
    endsequence

    a_master_start: assert property (s_start |=> s_sel_low)
        else $error("master start did not lower select");
    a_sel_idle: assert property (st_q == spx_pkg::M_IDLE |-> cs_q)
        else $error("select low while master idle");
    a_idle_pol: assert property ($stable(ctrl_q) && st_q == spx_pkg::M_END
                                 |-> sclk_q == cpol)
        else $error("idle clock not at polarity");
    a_half_period: assert property (st_q == spx_pkg::M_RUN && $stable(div_q)
                                    && $changed(sclk_q) && $past(st_q) ==
                                    spx_pkg::M_RUN |-> hold_q == div_q)
        else $error("half period differs from divider");
    a_byte_edges: assert property (st_q == spx_pkg::M_RUN ##1
                                   st_q == spx_pkg::M_END |=> tog_q[3:0] == 4'h0)
        else $error("burst not whole bytes of sixteen edges");
    a_pin_master: assert property (mst |-> !master_in_slave_out_pin_oe_o
                                   && master_out_slave_in_pin_oe_o
                                   && serial_clock_pin_oe_o)
        else $error("pin direction wrong in master role");
    a_pin_slave: assert property (slv |-> master_in_slave_out_pin_oe_o
                                  && !master_out_slave_in_pin_oe_o
                                  && !serial_clock_pin_oe_o && !chip_select_pin_n_oe_o)
        else $error("pin direction wrong in slave role");
    a_ovf_flag: assert property (done && rxf.full |=> ovf_q[*2])
        else $error("overflow flag not held");
    a_udf_flag: assert property (udf_set |=> udf_q)
        else $error("underflow flag not set");
    a_fifo_levels: assert property (rxf.count <= 3'h4 && txf.count <= 3'h4)
        else $error("fifo level out of range");
    a_status_rst: assert property ($fell(rst_i) |-> status == spx_pkg::STATUS_RESET)
        else $error("status not zero after reset");
endmodule

// ---- spx_partner.sv ----
// behavioural spi slave standing on the far side of the port
`timescale 1ns/1ps
module spx_partner (
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       mosi_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic [7:0]      rx_o,
    output int              edges_o
);
    logic [7:0] sh_q; // bits still to send
    initial
    begin
        miso_o = 1'b0;
        rx_o = 8'h00;
        edges_o = 0;
        sh_q = 8'h00;
    end
    // frame start loads the byte, msb goes first when phase is zero
    always @(negedge cs_n_i)
    begin
        edges_o = 0;
        sh_q = tx_i;
        if (!cpha_i)
        begin
            miso_o = sh_q[7];
            sh_q = sh_q << 1;
        end
    end
    // released line shows the inverse of its last bit
    always @(posedge cs_n_i) miso_o = ~miso_o;
    // sample on one edge, launch on the other, same mode as the port
    always @(sclk_i)
    begin
        if (!cs_n_i)
        begin
            edges_o++;
            if ((sclk_i != cpol_i) != cpha_i)
                rx_o = {rx_o[6:0], mosi_i};
            else
            begin
                miso_o = sh_q[7];
                sh_q = sh_q << 1;
            end
        end
    end
endmodule

// ---- spx_tb.sv ----
// self-checking bench for the serial port in master and slave roles
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0;  // system clock
    logic        rst_i = 1'b1;  // synchronous reset
    logic [31:0] adr_i = '0;    // bus address
    logic [31:0] dat_i = '0;    // bus write data
    logic        we_i = 1'b0;   // bus direction
    logic [3:0]  sel_i = 4'hF;  // byte selects
    logic        stb_i = 1'b0;  // strobe
    logic        cyc_i = 1'b0;  // cycle
    logic [31:0] dat_o;         // read data
    logic        ack_o;         // bus answer
    logic miso_o, miso_oe, mosi_o, mosi_oe, sclk_o, sclk_oe, cs_o, cs_oe, p_miso;
    logic        sclk_tb = 1'b0; // bench-driven clock in slave role
    logic        cs_tb = 1'b1;   // bench-driven select in slave role
    logic        mosi_tb = 1'b0; // bench-driven data in slave role
    logic        p_cpol = 1'b0;  // partner mode
    logic        p_cpha = 1'b0;
    logic [7:0]  p_tx = 8'h00;   // partner outgoing byte
    logic [7:0]  p_rx;           // partner received byte
    int          p_edges;        // partner edge count
    int          fails = 0;
    int          checks = 0;
    int          cyc_n = 0;
    logic [31:0] q;
    // resolved pin levels from all enables
    wire sclk_w = sclk_oe ? sclk_o : sclk_tb;
    wire cs_w   = cs_oe ? cs_o : cs_tb;
    wire mosi_w = mosi_oe ? mosi_o : mosi_tb;
    wire miso_w = miso_oe ? miso_o : p_miso;
    always #2.5 clk_i = ~clk_i;
    spx_port DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i),
        .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .dat_o(dat_o), .ack_o(ack_o),
        .master_in_slave_out_pin_i(miso_w), .master_in_slave_out_pin_o(miso_o),
        .master_in_slave_out_pin_oe_o(miso_oe), .master_out_slave_in_pin_i(mosi_w),
        .master_out_slave_in_pin_o(mosi_o), .master_out_slave_in_pin_oe_o(mosi_oe),
        .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sclk_o),
        .serial_clock_pin_oe_o(sclk_oe), .chip_select_pin_n_i(cs_w),
        .chip_select_pin_n_o(cs_o), .chip_select_pin_n_oe_o(cs_oe));
    spx_partner peer (.sclk_i(sclk_w), .cs_n_i(cs_w), .mosi_i(mosi_w), .cpol_i(p_cpol),
        .cpha_i(p_cpha), .tx_i(p_tx), .miso_o(p_miso), .rx_o(p_rx), .edges_o(p_edges));
    ////////////////////////////////////////////////////////////////////////////////
    // verdict and hang guard
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            fails++;
            give_verdict();
        end
    end
    // compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        adr_i <= a; we_i <= w; dat_i <= d; cyc_i <= 1'b1; stb_i <= 1'b1;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask
    // wait for the select line to reach a level
    task automatic wait_cs(input logic lvl);
        while (cs_w !== lvl) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // reset values, read-only status, unmapped place
    task automatic t_regs();
        wb(spx_pkg::ADR_STATUS, 1'b0, '0); check(q, 32'h0);
        wb(spx_pkg::ADR_DIV, 1'b0, '0); check(q, 32'h1B);
        wb(spx_pkg::ADR_STATUS, 1'b1, 32'hFFFF);
        wb(spx_pkg::ADR_STATUS, 1'b0, '0); check(q, 32'h0);
        wb(32'hFFFF0A20, 1'b0, '0); check(q, 32'h0);
    endtask
    // one master byte in a given mode, divider 3
    task automatic t_master(input logic pol, input logic pha, input logic [7:0] tx,
                            input logic [7:0] rx);
        realtime t0;
        p_cpol = pol; p_cpha = pha; p_tx = rx;
        wb(spx_pkg::ADR_DIV, 1'b1, 32'h3);
        wb(spx_pkg::ADR_CTRL, 1'b1, {28'h0, pha, pol, 2'b11});
        repeat (2) @(posedge clk_i); check(sclk_w, pol);
        wb(spx_pkg::ADR_TX, 1'b1, {24'h0, tx});
        wait_cs(1'b0);
        check({miso_oe, mosi_oe, sclk_oe, cs_oe}, 4'h7);
        @(sclk_w); t0 = $realtime;
        @(sclk_w); check(32'($rtoi($realtime - t0)), 32'h14);
        wait_cs(1'b1);
        check(p_edges, 32'h10);
        check(p_rx, tx);
        check(sclk_w, pol);
        wb(spx_pkg::ADR_STATUS, 1'b0, '0); check(q, 32'h0100);
        wb(spx_pkg::ADR_RX, 1'b0, '0); check(q, {24'h0, rx});
    endtask
    // five bytes into a four-deep receive fifo
    task automatic t_overflow();
        for (int i = 0; i < 5; i++) wb(spx_pkg::ADR_TX, 1'b1, 32'h50 + i);
        wait_cs(1'b0);
        wait_cs(1'b1);
        wb(spx_pkg::ADR_STATUS, 1'b0, '0); check(q, 32'h0480);
        wb(spx_pkg::ADR_STATUS, 1'b0, '0); check(q, 32'h0400);
        for (int i = 0; i < 4; i++) wb(spx_pkg::ADR_RX, 1'b0, '0);
        wb(spx_pkg::ADR_STATUS, 1'b0, '0); check(q, 32'h0);
    endtask
    // slave select with an empty transmit fifo
    task automatic t_slave_underflow();
        wb(spx_pkg::ADR_CTRL, 1'b1, 32'h1);
        cs_tb <= 1'b0;
        repeat (10) @(posedge clk_i);
        check({miso_oe, mosi_oe, sclk_oe, cs_oe}, 4'h8);
        cs_tb <= 1'b1;
        wb(spx_pkg::ADR_STATUS, 1'b0, '0); check(q, 32'h0010);
        wb(spx_pkg::ADR_STATUS, 1'b0, '0); check(q, 32'h0);
    endtask
    // one slave byte clocked by the bench at 10 Mb, mode zero
    task automatic t_slave_byte();
        logic [7:0] got;
        logic [7:0] sb;
        got = 8'h00;
        sb = 8'h96;
        wb(spx_pkg::ADR_TX, 1'b1, 32'h69);
        cs_tb <= 1'b0;
        repeat (10) @(posedge clk_i);
        for (int i = 7; i >= 0; i--)
        begin
            mosi_tb <= sb[i];
            repeat (10) @(posedge clk_i);
            got[i] = miso_w;
            sclk_tb <= 1'b1;
            repeat (10) @(posedge clk_i);
            sclk_tb <= 1'b0;
        end
        repeat (10) @(posedge clk_i);
        cs_tb <= 1'b1;
        check({24'h0, got}, 32'h69);
        wb(spx_pkg::ADR_RX, 1'b0, '0); check(q, {24'h0, sb});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        for (int m = 0; m < 4; m++) t_master(m[1], m[0], 8'hA5 ^ m[7:0], 8'h3C + m[7:0]);
        t_overflow();
        t_slave_underflow();
        t_slave_byte();
        give_verdict();
    end
endmodule
